/* logic/chan_image_pkg.sv */
// Package for the per-channel direct-access process image.
// Assumes a byte-addressed backplane bus with 1, 2 or 4 byte accesses.
package chan_image_pkg;
  localparam int unsigned CHAN_SPAN = 8;
  localparam int unsigned CHAN_COUNT = 3;
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_MOTION = 5'h01;
  localparam logic [4:0] OFF_MODE = 5'h02;
  localparam logic [4:0] OFF_HANDSHAKE = 5'h03;
  localparam logic [4:0] OFF_POSITION = 5'h04;
  localparam logic [4:0] OFF_RESERVED = 5'h04;
  // Control byte 0 keeps only bit 3; byte 1 drops bits 5 and 4
  localparam logic [7:0] MASK_ERROR_ACK = 8'h08;
  localparam logic [7:0] MASK_COMMAND = 8'hcf;
  localparam logic [7:0] MASK_HANDSHAKE = 8'haf;
  localparam logic [7:0] MASK_MOTION = 8'hf7;
  localparam logic [7:0] MASK_STATUS = 8'h9c;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned RETURN_PERIOD_MS = 8;
  localparam int unsigned POSITION_PERIOD_MS = 3;
  localparam int unsigned RETURN_CYCLES = CLK_HZ / 1000 * RETURN_PERIOD_MS;
  localparam int unsigned POSITION_CYCLES =
    CLK_HZ / 1000 * POSITION_PERIOD_MS;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] motion;
    logic [7:0] mode;
    logic [7:0] handshake;
  } return_sig_t;

  typedef struct packed {
    logic [7:0] error_ack;
    logic [7:0] command;
    logic [7:0] requested_mode;
    logic [7:0] mode_type;
  } control_sig_t;
endpackage

/* logic/chan_image.sv */
// Direct-access input/output image of three positioning channels.
// Assumes bus strobes and live channel signals share clk_sys.
`timescale 1ns/1ps
module chan_image
  import chan_image_pkg::*;
#(
  parameter int unsigned RETURN_TICKS = RETURN_CYCLES,
  parameter int unsigned POSITION_TICKS = POSITION_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [4:0] bus_addr,
  input wire logic [1:0] bus_size,
  input wire logic bus_read,
  input wire logic bus_write,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_ack,
  input wire return_sig_t [CHAN_COUNT-1:0] live_return,
  input wire logic [CHAN_COUNT-1:0][31:0] live_position,
  output control_sig_t [CHAN_COUNT-1:0] control_out
);
  logic [31:0] ret_cnt_reg;
  logic [31:0] pos_cnt_reg;
  return_sig_t [CHAN_COUNT-1:0] ret_reg;
  logic [CHAN_COUNT-1:0][31:0] pos_reg;
  logic [7:0] in_img [CHAN_COUNT*CHAN_SPAN];
  logic [7:0] out_img [CHAN_COUNT*CHAN_SPAN];
  logic ret_tick;
  logic pos_tick;
  logic [2:0] nbytes;
  logic [31:0] rdata_next;
  logic [4:0] cmd_addr_ch1;

  // Byte count of the access: 0 one, 1 two, else four
  function automatic logic [2:0] size_bytes(input logic [1:0] s);
    case (s)
      2'h0: size_bytes = 3'h1;
      2'h1: size_bytes = 3'h2;
      default: size_bytes = 3'h4;
    endcase
  endfunction

  // Keep documented-zero control bits clear regardless of host writes
  function automatic logic [7:0] ctrl_mask(input logic [4:0] a);
    case (5'(a % 5'(CHAN_SPAN)))
      OFF_STATUS: ctrl_mask = MASK_ERROR_ACK;
      OFF_MOTION: ctrl_mask = MASK_COMMAND;
      OFF_MODE: ctrl_mask = 8'hff;
      OFF_HANDSHAKE: ctrl_mask = 8'hff;
      default: ctrl_mask = 8'h00;
    endcase
  endfunction

  assign ret_tick = (ret_cnt_reg == 32'(RETURN_TICKS - 1));
  assign pos_tick = (pos_cnt_reg == 32'(POSITION_TICKS - 1));
  assign nbytes = size_bytes(bus_size);
  assign cmd_addr_ch1 = 5'(CHAN_SPAN) + OFF_MOTION;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ret_cnt_reg <= 32'h0;
      pos_cnt_reg <= 32'h0;
    end else begin
      ret_cnt_reg <= ret_tick ? 32'h0 : ret_cnt_reg + 32'h1;
      pos_cnt_reg <= pos_tick ? 32'h0 : pos_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ret_reg <= '0;
      pos_reg <= {CHAN_COUNT{POS_RESET}};
    end else begin
      if (ret_tick) ret_reg <= live_return;
      if (pos_tick) pos_reg <= live_position;
    end
  end

  // byte layout of the input image
  // params assigned flag comes from the ret_reg snapshot of the live status
  always_comb begin
    for (int c = 0; c < CHAN_COUNT; c++) begin
      in_img[c*CHAN_SPAN + OFF_STATUS] = ret_reg[c].status & MASK_STATUS;
      in_img[c*CHAN_SPAN + OFF_MOTION] = ret_reg[c].motion & MASK_MOTION;
      in_img[c*CHAN_SPAN + OFF_MODE] = ret_reg[c].mode;
      in_img[c*CHAN_SPAN + OFF_HANDSHAKE] =
        ret_reg[c].handshake & MASK_HANDSHAKE;
      for (int b = 0; b < 4; b++) begin
        in_img[c*CHAN_SPAN + OFF_POSITION + b] = pos_reg[c][31-8*b -: 8];
      end
    end
  end

  // read assembly, lowest address in the top byte
  always_comb begin
    rdata_next = 32'h0;
    for (int b = 0; b < 4; b++) begin
      if (3'(b) < nbytes &&
          (int'(bus_addr) + b) < CHAN_COUNT*CHAN_SPAN) begin
        rdata_next[8*(32'(nbytes)-1-b) +: 8] = in_img[int'(bus_addr) + b];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 32'h0;
      bus_ack <= 1'b0;
    end else begin
      bus_rdata <= bus_read ? rdata_next : 32'h0;
      bus_ack <= bus_read | bus_write;
    end
  end

  // byte-wise write into the output image
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CHAN_COUNT*CHAN_SPAN; i++) out_img[i] <= CTRL_RESET;
    end else if (bus_write) begin
      for (int b = 0; b < 4; b++) begin
        if (3'(b) < nbytes &&
            (int'(bus_addr) + b) < CHAN_COUNT*CHAN_SPAN) begin
          out_img[int'(bus_addr) + b] <=
            bus_wdata[8*(32'(nbytes)-1-b) +: 8] &
            ctrl_mask(5'(int'(bus_addr) + b));
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      control_out <= '0;
    end else begin
      for (int c = 0; c < CHAN_COUNT; c++) begin
        control_out[c] <= {out_img[c*CHAN_SPAN + OFF_STATUS],
          out_img[c*CHAN_SPAN + OFF_MOTION],
          out_img[c*CHAN_SPAN + OFF_MODE],
          out_img[c*CHAN_SPAN + OFF_HANDSHAKE]};
      end
    end
  end

  a_read_ack_timing: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (bus_read | bus_write) |=> bus_ack)
    else $error("access not acknowledged");

  a_ack_only_request: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !(bus_read | bus_write) |=> !bus_ack)
    else $error("spurious acknowledge");

  // read data is zero unless a read was taken
  a_rdata_idle: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !bus_read |=> bus_rdata == 32'h0)
    else $error("read data without a read");

  // return snapshot taken on the tick, held in between
  a_ret_period: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    ret_tick |=> ret_reg == $past(live_return))
    else $error("return snapshot not taken");

  a_ret_hold: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !ret_tick |=> $stable(ret_reg))
    else $error("return signals changed between refreshes");

  a_pos_period: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    pos_tick |=> pos_reg == $past(live_position))
    else $error("position sample not whole");

  a_pos_hold: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    !pos_tick |=> $stable(pos_reg))
    else $error("position changed between samples");

  a_cmd_zero_bits: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    control_out[0].command[5:4] == 2'h0)
    else $error("reserved command bits set");

  a_ack_zero_bits: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (control_out[0].error_ack & ~MASK_ERROR_ACK) == 8'h0)
    else $error("reserved ack bits set");

  a_status_internal: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    bus_read && bus_size == 2'h0 && bus_addr == OFF_STATUS
    |=> (bus_rdata[7:0] & ~MASK_STATUS) == 8'h0)
    else $error("internal status bits not zero");

  a_motion_bit3: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    bus_read && bus_size == 2'h0 && bus_addr == OFF_MOTION
    |=> bus_rdata[3] == 1'b0)
    else $error("motion bit 3 not zero");

  a_mode_byte: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    bus_read && bus_size == 2'h0 && bus_addr == OFF_MODE
    |=> bus_rdata[31:8] == 24'h0)
    else $error("single byte read has upper bytes set");

  // a lone command write reaches the control outputs
  sequence s_cmd_write;
    bus_write && bus_size == 2'h0 && bus_addr == cmd_addr_ch1;
  endsequence

  a_cmd_lands: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    s_cmd_write ##1 !bus_write
    |=> control_out[1].command == ($past(bus_wdata[7:0], 2) & MASK_COMMAND))
    else $error("command write did not land");
endmodule

/* verif/host_model.sv */
// Host controller model on the backplane bus.
// Assumes one ack pulse follows each one-cycle request.
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys,
  output logic [4:0] bus_addr,
  output logic [1:0] bus_size,
  output logic bus_read,
  output logic bus_write,
  output logic [31:0] bus_wdata
);
  initial begin
    bus_addr = 5'h00;
    bus_size = 2'h0;
    bus_read = 1'b0;
    bus_write = 1'b0;
    bus_wdata = 32'h0;
  end

  // direct access only, startup routine finished before
  task automatic access(input logic [4:0] a, input logic [1:0] s,
      input logic rd, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_size <= s;
    bus_read <= rd;
    bus_write <= !rd;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_read <= 1'b0;
    bus_write <= 1'b0;
    // Released address and data lines must not keep showing the last value
    bus_addr <= ~a;
    bus_wdata <= ~d;
    @(posedge clk_sys);
  endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the three-channel direct-access image.
// Assumes short refresh counts so snapshots land quickly.
`timescale 1ns/1ps
module tb;
  import chan_image_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] bus_addr;
  logic [1:0] bus_size;
  logic bus_read;
  logic bus_write;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic bus_ack;
  return_sig_t [CHAN_COUNT-1:0] live_return = '0;
  logic [CHAN_COUNT-1:0][31:0] live_position = '0;
  control_sig_t [CHAN_COUNT-1:0] control_out;
  logic [31:0] expect_q[$];
  integer seed = 35963;
  int failures = 0;
  int tests_run = 0;
  logic [4:0] b;
  logic [31:0] w;
  return_sig_t r;

  host_model host (.clk_sys(clk_sys), .bus_addr(bus_addr),
    .bus_size(bus_size), .bus_read(bus_read), .bus_write(bus_write),
    .bus_wdata(bus_wdata));
  chan_image #(.RETURN_TICKS(16), .POSITION_TICKS(6)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_size(bus_size), .bus_read(bus_read), .bus_write(bus_write),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .live_return(live_return), .live_position(live_position),
    .control_out(control_out));

  initial forever #4 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic acc(input logic [4:0] a, input logic [1:0] s,
      input logic rd, input logic [31:0] d, input logic [31:0] want);
    expect_q.push_back(want);
    host.access(a, s, rd, d);
  endtask

  task automatic wr(input logic [4:0] a, input logic [1:0] s,
      input logic [31:0] d, input logic [31:0] want);
    acc(a, s, 1'b0, d, 32'h0);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(control_out[a[4:3]], want);
  endtask

  always @(negedge clk_sys) begin
    if (bus_ack === 1'b1) begin
      if (expect_q.size() == 0) check(32'h0, 32'h1);
      else check(bus_rdata, expect_q.pop_front());
    end
  end

  initial begin
    #200000;
    failures++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      live_return[c] <= $random(seed);
      live_position[c] <= $random(seed);
    end
    repeat (24) @(posedge clk_sys);
    for (int c = 0; c < 3; c++) begin
      b = 5'(c * 8);
      r = live_return[c];
      // fixed-zero bits of bytes 0 and 1
      acc(b, 2'h1, 1'b1, 32'h0,
        {16'h0, r.status & MASK_STATUS, r.motion & MASK_MOTION});
      // the same bytes one at a time
      acc(b, 2'h0, 1'b1, 32'h0, {24'h0, r.status & MASK_STATUS});
      acc(b + 5'h1, 2'h0, 1'b1, 32'h0, {24'h0, r.motion & MASK_MOTION});
      // mode and handshake as one word
      acc(b + 5'h2, 2'h1, 1'b1, 32'h0,
        {16'h0, r.mode, r.handshake & MASK_HANDSHAKE});
      acc(b + 5'h2, 2'h0, 1'b1, 32'h0, {24'h0, r.mode});
      acc(b + 5'h4, 2'h2, 1'b1, 32'h0, live_position[c]);
    end
    acc(5'h1c, 2'h0, 1'b1, 32'h0, 32'h0);
    for (int c = 0; c < 3; c++) begin
      b = 5'(c * 8);
      w = $random(seed);
      // dword write keeps only documented bits
      wr(b, 2'h2, {16'hffff, w[15:0]}, {16'h08cf, w[15:0]});
      wr(b + 5'h1, 2'h0, 32'h88, {16'h0888, w[15:0]});
      // mode and mode type as one word
      wr(b + 5'h2, 2'h1, {16'h0, w[31:16]}, {16'h0888, w[31:16]});
      wr(b + 5'h4, 2'h0, 32'hff, {16'h0888, w[31:16]});
    end
    // a changed live value shows after one refresh period
    @(posedge clk_sys);
    live_return[1] <= $random(seed);
    live_position[1] <= $random(seed);
    repeat (20) @(posedge clk_sys);
    r = live_return[1];
    acc(5'h08, 2'h1, 1'b1, 32'h0,
      {16'h0, r.status & MASK_STATUS, r.motion & MASK_MOTION});
    acc(5'h0c, 2'h2, 1'b1, 32'h0, live_position[1]);
    // Mid-run reset clears the control image, then refresh restarts
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(negedge clk_sys);
    for (int c = 0; c < 3; c++) begin
      check(control_out[c], 32'h0);
    end
    check(32'(bus_ack), 32'h0);
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (24) @(posedge clk_sys);
    acc(5'h04, 2'h2, 1'b1, 32'h0, live_position[0]);
    repeat (2) @(posedge clk_sys);
    check(32'(expect_q.size()), 32'h0);
    close_out();
  end
endmodule
